/* File: core/protection_logic.sv */
// Purpose: Scram initiation, seal-in, reset delay and output drive of the protection logic
// Assumes: AXI4-Lite slave for setpoints and control; all inputs synchronous to clk
// Notes: Outputs are active low so reset and dead divisions read as tripped
`timescale 1ns/1ps
module protection_logic #(
    parameter int unsigned RESET_DELAY_CYCLES = protection_pkg::RESET_DELAY_CYCLES_DEF
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic awvalid,
    output logic awready,
    input wire logic [protection_pkg::ADDR_W-1:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [protection_pkg::DATA_W-1:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [protection_pkg::ADDR_W-1:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [protection_pkg::DATA_W-1:0] rdata,
    output logic [1:0] rresp,
    input wire logic [protection_pkg::NUM_DIV-1:0][protection_pkg::NUM_ANA-1:0][protection_pkg::PV_W-1:0] process_value,
    input wire logic [protection_pkg::NUM_DIV-1:0] stop_valve_closed,
    input wire logic [protection_pkg::NUM_DIV-1:0] cv_oil_low,
    input wire logic [protection_pkg::NUM_DIV-1:0] steam_isolation,
    input wire logic [protection_pkg::NUM_DIV-1:0] pool_temp_high,
    input wire logic [protection_pkg::NUM_DIV-1:0] neutron_trip,
    input wire logic [protection_pkg::NUM_DIV-1:0] div_power_ok,
    input wire logic manual_button_a,
    input wire logic manual_button_b,
    output logic [protection_pkg::NUM_SW-1:0] switch_div2_n,
    output logic [protection_pkg::NUM_SW-1:0] switch_div3_n,
    output logic backup_relay_n,
    output logic rod_follow_n,
    output logic pump_trip_n,
    output logic [protection_pkg::NUM_DIV-1:0] div_trip_n
);
    import protection_pkg::*;

    localparam logic [TIMER_W-1:0] TIMER_LAST = TIMER_W'(RESET_DELAY_CYCLES - 1);
    localparam int DIV_II = 1;
    localparam int DIV_III = 2;
    localparam int SW_HALF = NUM_SW / 2;

    typedef struct packed {
        logic aw_got;
        logic [ADDR_W-1:0] aw_addr;
        logic w_got;
        logic [DATA_W-1:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [DATA_W-1:0] rdata;
        logic [1:0] rresp;
        logic [NUM_DIV-1:0][NUM_ANA-1:0][PV_W-1:0] sp;
        latch_state_t latch;
        logic [TIMER_W-1:0] timer;
        logic manual;
        logic auto;
        logic pump;
        logic [NUM_SW-1:0] sw2_n;
        logic [NUM_SW-1:0] sw3_n;
        logic backup_n;
        logic follow_n;
        logic pump_n;
        logic [NUM_DIV-1:0] div_n;
    } state_t;

    state_t q;
    state_t d;

    logic [NUM_DIV-1:0][NUM_TRIP-1:0] trips;
    logic [NUM_DIV-1:0] vote;
    logic [NUM_DIV-1:0] turbine_vote;
    logic manual_both;
    logic auto_now;
    logic scram_cause;
    logic scram_now;
    logic reset_req;
    logic sw_hit;
    logic [ADDR_W-1:0] sw_off;

    // Comes out of reset sealed in, so no switch, backup relay or rod follow output energises before the delay runs
    function automatic state_t reset_state();
        state_t s;
        s = '0;
        for (int i = 0; i < NUM_DIV; i++)
        begin
            s.sp[i][ANA_RX_PRESS] = SP_RX_PRESS_RST;
            s.sp[i][ANA_WATER_LEVEL] = SP_WATER_LEVEL_RST;
            s.sp[i][ANA_DRYWELL_PRESS] = SP_DRYWELL_RST;
            s.sp[i][ANA_ACCUM_PRESS] = SP_ACCUM_RST;
            s.sp[i][ANA_POWER] = SP_POWER_40PCT;
        end
        s.latch = LATCH_TIMING;
        return s;
    endfunction : reset_state

    localparam state_t RESET_Q = reset_state();

    function automatic logic sp_mapped(input logic [ADDR_W-1:0] a);
        logic [ADDR_W-1:0] off;
        off = a - ADDR_SP_BASE;
        return (a >= ADDR_SP_BASE) && (off < ADDR_SP_SPAN) && (32'(off[4:2]) < NUM_ANA);
    endfunction : sp_mapped

    genvar g;
    generate
        for (g = 0; g < NUM_DIV; g++)
        begin : g_div
            setpoint_trip_module u_stm (
                .clk(clk),
                .resetn(resetn),
                .process_value(process_value[g]),
                .setpoint(q.sp[g]),
                .stop_valve_closed(stop_valve_closed[g]),
                .cv_oil_low(cv_oil_low[g]),
                .steam_isolation(steam_isolation[g]),
                .pool_temp_high(pool_temp_high[g]),
                .trip(trips[g])
            );
            voting_unit u_vote (
                .clk(clk),
                .resetn(resetn),
                .div_trips(trips),
                .neutron_trip(neutron_trip),
                .power_ok(div_power_ok[g]),
                .vote(vote[g]),
                .turbine_vote(turbine_vote[g])
            );
        end
    endgenerate

    // Channels free while nothing is pending; one write and one read at a time
    assign awready = !q.aw_got && !q.bvalid;
    assign wready = !q.w_got && !q.bvalid;
    assign arready = !q.rvalid;
    assign manual_both = manual_button_a & manual_button_b;
    assign auto_now = at_least_two(vote);
    assign scram_cause = auto_now | manual_both;
    assign sw_off = q.aw_addr - ADDR_SP_BASE;
    assign sw_hit = sp_mapped(q.aw_addr);

    always_comb
    begin
        d = q;
        reset_req = 1'b0;
        if (awvalid && awready)
        begin
            d.aw_got = 1'b1;
            d.aw_addr = awaddr;
        end
        if (wvalid && wready)
        begin
            d.w_got = 1'b1;
            d.w_data = wdata;
            d.w_strb = wstrb;
        end
        if (q.aw_got && q.w_got)
        begin
            d.aw_got = 1'b0;
            d.w_got = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = RESP_OKAY;
            if (q.aw_addr == ADDR_CTRL)
                reset_req = q.w_strb[0] & q.w_data[CTRL_RESET_BIT];
            else if (sw_hit)
            begin
                if (q.w_strb[0])
                    d.sp[sw_off[6:5]][sw_off[4:2]][7:0] = q.w_data[7:0];
                if (q.w_strb[1])
                    d.sp[sw_off[6:5]][sw_off[4:2]][15:8] = q.w_data[15:8];
            end
            else if ((q.aw_addr != ADDR_STATUS) && (q.aw_addr != ADDR_TRIPS))
                d.bresp = RESP_SLVERR;
        end
        if (q.bvalid && bready)
            d.bvalid = 1'b0;
        if (q.rvalid && rready)
            d.rvalid = 1'b0;
        if (arvalid && arready)
        begin
            d.rvalid = 1'b1;
            d.rresp = RESP_OKAY;
            d.rdata = '0;
            if (araddr == ADDR_CTRL)
                d.rdata = '0;
            else if (araddr == ADDR_STATUS)
            begin
                d.rdata[ST_LATCHED] = q.latch != LATCH_CLEAR;
                d.rdata[ST_EXPIRED] = q.latch == LATCH_ARMED;
                d.rdata[ST_MANUAL] = q.manual;
                d.rdata[ST_PUMP] = q.pump;
                d.rdata[ST_AUTO] = q.auto;
                d.rdata[ST_DIV_LSB +: NUM_DIV] = vote;
            end
            else if (araddr == ADDR_TRIPS)
                d.rdata = trips;
            else if (sp_mapped(araddr))
                d.rdata[PV_W-1:0] = q.sp[araddr[6:5] - ADDR_SP_BASE[6:5]][araddr[4:2]];
            else
                d.rresp = RESP_SLVERR;
        end

        d.auto = auto_now;
        case (q.latch)
            LATCH_CLEAR:
            begin
                if (scram_cause)
                begin
                    d.latch = LATCH_TIMING;
                    d.timer = '0;
                    d.manual = manual_both;
                end
            end
            LATCH_TIMING:
            begin
                if (manual_both)
                    d.manual = 1'b1;
                if (q.timer >= TIMER_LAST)
                    d.latch = LATCH_ARMED;
                else
                    d.timer = q.timer + 1'b1;
            end
            LATCH_ARMED:
            begin
                if (manual_both)
                    d.manual = 1'b1;
                // A live cause beats the reset request
                if (reset_req && !scram_cause)
                begin
                    d.latch = LATCH_CLEAR;
                    d.manual = 1'b0;
                end
            end
            default:
            begin
                d.latch = LATCH_TIMING;
                d.timer = '0;
            end
        endcase
        scram_now = d.latch != LATCH_CLEAR;

        // Only divisions II and III own switches; a dead division opens its own
        d.sw2_n = {NUM_SW{!(scram_now || !div_power_ok[DIV_II])}};
        d.sw3_n = {NUM_SW{!(scram_now || !div_power_ok[DIV_III])}};
        if (manual_button_a)
            d.sw2_n[SW_HALF-1:0] = '0;
        if (manual_button_b)
            d.sw3_n[NUM_SW-1:SW_HALF] = '0;
        d.backup_n = !scram_now;
        d.follow_n = !scram_now;
        d.pump = |turbine_vote;
        d.pump_n = !(|turbine_vote);
        d.div_n = ~vote;
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            q <= RESET_Q;
        else
            q <= d;
    end

    assign bvalid = q.bvalid;
    assign bresp = q.bresp;
    assign rvalid = q.rvalid;
    assign rdata = q.rdata;
    assign rresp = q.rresp;
    assign switch_div2_n = q.sw2_n;
    assign switch_div3_n = q.sw3_n;
    assign backup_relay_n = q.backup_n;
    assign rod_follow_n = q.follow_n;
    assign pump_trip_n = q.pump_n;
    assign div_trip_n = q.div_n;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence s_armed_reset;
        (q.latch == LATCH_ARMED) && reset_req && !scram_cause;
    endsequence
    sequence s_cause_while_clear;
        (q.latch == LATCH_CLEAR) && scram_cause;
    endsequence

    a_auto_latches: assert property (s_cause_while_clear |=> (q.latch == LATCH_TIMING) && (q.timer == '0))
        else $error("scram cause not latched");
    a_seal_in: assert property ((q.latch == LATCH_TIMING) |=> (q.latch != LATCH_CLEAR))
        else $error("latch cleared during delay");
    a_reset_clears: assert property (s_armed_reset |=> (q.latch == LATCH_CLEAR))
        else $error("reset after delay ignored");
    a_clear_cause: assert property ((q.latch == LATCH_ARMED) && scram_cause |=> (q.latch == LATCH_ARMED))
        else $error("reset won over live trip");
    a_timer_expiry: assert property ((q.latch == LATCH_TIMING) && (q.timer == TIMER_LAST) |=> (q.latch == LATCH_ARMED))
        else $error("delay expiry missed");
    a_single_no_scram: assert property ((q.latch == LATCH_CLEAR) && ($countones(vote) <= 1) && !manual_both
        |=> (q.latch == LATCH_CLEAR)) else $error("single division scrammed");
    a_outputs_tripped: assert property ((q.latch != LATCH_CLEAR) |-> (switch_div2_n == '0) && (switch_div3_n == '0)
        && !backup_relay_n && !rod_follow_n) else $error("latched scram not driven");
    a_manual_group_a: assert property (manual_button_a && !manual_button_b |=> (switch_div2_n[SW_HALF-1:0] == '0))
        else $error("button A group not cut");
    a_manual_group_b: assert property (manual_button_b && !manual_button_a |=> (switch_div3_n[NUM_SW-1:SW_HALF] == '0))
        else $error("button B group not cut");
    a_manual_both: assert property (manual_both |=> !backup_relay_n && !rod_follow_n)
        else $error("manual scram not driven");
    a_dead_division: assert property (!div_power_ok[DIV_II] |=> (switch_div2_n == '0) ##1 !div_trip_n[DIV_II])
        else $error("dead division not tripped");
    a_pump_trip: assert property ((|turbine_vote) |=> !pump_trip_n)
        else $error("pump trip missing");
endmodule : protection_logic

/* File: include/protection_pkg.sv */
// Purpose: Shared constants, types and helpers for the scram voting logic
// Assumes: 125 MHz clock, AXI4-Lite register access with 32-bit data
// Notes: Internal trip levels are active high; pins toward the plant are active low
package protection_pkg;
    localparam int NUM_DIV = 4;
    localparam int NUM_ANA = 5;
    localparam int NUM_TRIP = 8;
    localparam int PV_W = 16;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int NUM_SW = 8;
    // Analog variable slots
    localparam int ANA_RX_PRESS = 0;
    localparam int ANA_WATER_LEVEL = 1;
    localparam int ANA_DRYWELL_PRESS = 2;
    localparam int ANA_ACCUM_PRESS = 3;
    localparam int ANA_POWER = 4;
    // Slots that trip when falling below the setpoint
    localparam logic [NUM_ANA-1:0] ANA_LOW_TRIP = 5'h0A;
    // Trip vector bits
    localparam int TRIP_STOP_VALVE = 0;
    localparam int TRIP_CV_OIL = 1;
    localparam int TRIP_RX_PRESS = 2;
    localparam int TRIP_WATER_LEVEL = 3;
    localparam int TRIP_DRYWELL = 4;
    localparam int TRIP_ISOLATION = 5;
    localparam int TRIP_ACCUM = 6;
    localparam int TRIP_POOL_TEMP = 7;
    // Setpoint reset values; power slot holds 40% of full scale
    localparam logic [PV_W-1:0] SP_RX_PRESS_RST = 16'hC000;
    localparam logic [PV_W-1:0] SP_WATER_LEVEL_RST = 16'h4000;
    localparam logic [PV_W-1:0] SP_DRYWELL_RST = 16'h8000;
    localparam logic [PV_W-1:0] SP_ACCUM_RST = 16'h3000;
    localparam logic [PV_W-1:0] SP_POWER_40PCT = 16'h6666;
    // Register map
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_TRIPS = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_SP_BASE = 8'h40;
    localparam logic [ADDR_W-1:0] ADDR_SP_SPAN = 8'h80;
    localparam int CTRL_RESET_BIT = 0;
    localparam int ST_LATCHED = 0;
    localparam int ST_EXPIRED = 1;
    localparam int ST_MANUAL = 2;
    localparam int ST_PUMP = 3;
    localparam int ST_AUTO = 4;
    localparam int ST_DIV_LSB = 8;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Timing
    localparam int unsigned CLK_HZ = 125000000;
    localparam int unsigned RESET_DELAY_MS = 10000;
    localparam int unsigned RESET_DELAY_CYCLES_DEF = RESET_DELAY_MS * (CLK_HZ / 1000);
    localparam int TIMER_W = 31;

    typedef enum logic [2:0] {
        LATCH_CLEAR = 3'h1,
        LATCH_TIMING = 3'h2,
        LATCH_ARMED = 3'h4
    } latch_state_t;

    function automatic logic at_least_two(input logic [NUM_DIV-1:0] v);
        logic [2:0] n;
        n = 3'h0;
        for (int i = 0; i < NUM_DIV; i++)
        begin
            n = n + {2'h0, v[i]};
        end
        return n >= 3'h2;
    endfunction : at_least_two
endpackage : protection_pkg

/* File: core/setpoint_trip_module.sv */
// Purpose: One division's comparison of process values against stored setpoints
// Assumes: Setpoints arrive from the register file; discrete trips are active high
// Notes: Power above the permissive gates both turbine trips
`timescale 1ns/1ps
module setpoint_trip_module (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [protection_pkg::NUM_ANA-1:0][protection_pkg::PV_W-1:0] process_value,
    input wire logic [protection_pkg::NUM_ANA-1:0][protection_pkg::PV_W-1:0] setpoint,
    input wire logic stop_valve_closed,
    input wire logic cv_oil_low,
    input wire logic steam_isolation,
    input wire logic pool_temp_high,
    output logic [protection_pkg::NUM_TRIP-1:0] trip
);
    import protection_pkg::*;
    typedef struct packed {
        logic [NUM_TRIP-1:0] trip;
    } stm_state_t;
    stm_state_t q;
    stm_state_t d;
    logic [NUM_ANA-1:0] beyond;

    always_comb
    begin
        for (int i = 0; i < NUM_ANA; i++)
        begin
            beyond[i] = ANA_LOW_TRIP[i] ? (process_value[i] < setpoint[i]) : (process_value[i] > setpoint[i]);
        end
        d = q;
        d.trip[TRIP_STOP_VALVE] = stop_valve_closed & beyond[ANA_POWER];
        d.trip[TRIP_CV_OIL] = cv_oil_low & beyond[ANA_POWER];
        d.trip[TRIP_RX_PRESS] = beyond[ANA_RX_PRESS];
        d.trip[TRIP_WATER_LEVEL] = beyond[ANA_WATER_LEVEL];
        d.trip[TRIP_DRYWELL] = beyond[ANA_DRYWELL_PRESS];
        d.trip[TRIP_ISOLATION] = steam_isolation;
        d.trip[TRIP_ACCUM] = beyond[ANA_ACCUM_PRESS];
        d.trip[TRIP_POOL_TEMP] = pool_temp_high;
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            q <= '0;
        else
            q <= d;
    end

    assign trip = q.trip;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    a_turbine_power_gate: assert property (!(process_value[ANA_POWER] > setpoint[ANA_POWER])
        |=> !trip[TRIP_STOP_VALVE] && !trip[TRIP_CV_OIL]) else $error("turbine trip below power permissive");
    a_high_press_trip: assert property (process_value[ANA_RX_PRESS] > setpoint[ANA_RX_PRESS]
        |=> trip[TRIP_RX_PRESS]) else $error("high pressure not tripped");
endmodule : setpoint_trip_module

/* File: core/voting_unit.sv */
// Purpose: One division's two-out-of-four vote over all divisions' trips
// Assumes: Neutron monitor trips come as four discrete channels
// Notes: Loss of this division's power forces its vote to trip
`timescale 1ns/1ps
module voting_unit (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [protection_pkg::NUM_DIV-1:0][protection_pkg::NUM_TRIP-1:0] div_trips,
    input wire logic [protection_pkg::NUM_DIV-1:0] neutron_trip,
    input wire logic power_ok,
    output logic vote,
    output logic turbine_vote
);
    import protection_pkg::*;
    typedef struct packed {
        logic vote;
        logic turbine;
    } vu_state_t;
    vu_state_t q;
    vu_state_t d;
    logic [NUM_TRIP-1:0] per_var;
    logic [NUM_DIV-1:0] column;

    always_comb
    begin
        for (int v = 0; v < NUM_TRIP; v++)
        begin
            for (int i = 0; i < NUM_DIV; i++)
            begin
                column[i] = div_trips[i][v];
            end
            per_var[v] = at_least_two(column);
        end
        d = q;
        // Fail safe: an unpowered unit reads as tripped
        d.vote = (|per_var) | at_least_two(neutron_trip) | !power_ok;
        d.turbine = per_var[TRIP_STOP_VALVE] | per_var[TRIP_CV_OIL];
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            q <= '{vote: 1'b1, turbine: 1'b0};
        else
            q <= d;
    end

    assign vote = q.vote;
    assign turbine_vote = q.turbine;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    a_power_loss_vote: assert property (!power_ok |=> vote) else $error("unpowered unit not tripped");
    a_neutron_vote: assert property (($countones(neutron_trip) >= 2) |=> vote) else $error("neutron vote missed");
endmodule : voting_unit

/* File: verif/plant_model.sv */
// Purpose: Plant model making the analog process values
// Assumes: Bench changes requests just after clk edges
// Notes: Quiet values sit well clear of the reset setpoints
`timescale 1ns/1ps
module plant_model (
    input wire logic [protection_pkg::NUM_DIV-1:0] press_hi,
    input wire logic pwr_hi,
    output logic [protection_pkg::NUM_DIV-1:0][protection_pkg::NUM_ANA-1:0][protection_pkg::PV_W-1:0] pv
);
    import protection_pkg::*;
    always_comb
    begin
        for (int d = 0; d < NUM_DIV; d++)
        begin
            pv[d][ANA_RX_PRESS] = press_hi[d] ? 16'hF000 : 16'h1000;
            pv[d][ANA_WATER_LEVEL] = 16'h8000;
            pv[d][ANA_DRYWELL_PRESS] = 16'h1000;
            pv[d][ANA_ACCUM_PRESS] = 16'h8000;
            // Power from first stage pressure, either side of 40%
            pv[d][ANA_POWER] = pwr_hi ? 16'hF000 : 16'h1000;
        end
    end
endmodule : plant_model

/* File: verif/protection_logic_tb.sv */
// Purpose: Directed bench for scram voting, seal-in and bus access
// Assumes: Reset delay shortened to 20 cycles
// Notes: Discrete trips and buttons driven straight from the bench
`timescale 1ns/1ps
module protection_logic_tb;
    import protection_pkg::*;
    logic clk = 1'h0;
    logic resetn = 1'h0;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic awready, wready, bvalid, arready, rvalid, bk_n, fol_n, pump_n;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, sw2, sw3;
    logic [31:0] wdata = 32'h0, rdata, rd_d;
    logic [1:0] bresp, rresp, rd_r, wr_b;
    logic [3:0] press_hi = 4'h0, sv = 4'h0, oil = 4'h0, iso = 4'h0, pool = 4'h0, ntr = 4'h0;
    logic [3:0] pwr_ok = 4'hF, dtrip_n;
    logic pwr_hi = 1'h0, btn_a = 1'h0, btn_b = 1'h0;
    logic [NUM_DIV-1:0][NUM_ANA-1:0][PV_W-1:0] pv;
    int n_errors = 0;
    int samples_checked = 0;
    always #4 clk = ~clk;
    plant_model pm (.press_hi(press_hi), .pwr_hi(pwr_hi), .pv(pv));
    protection_logic #(.RESET_DELAY_CYCLES(20)) uut (.clk(clk), .resetn(resetn),
        .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
        .wdata(wdata), .wstrb(4'hF), .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
        .rdata(rdata), .rresp(rresp), .process_value(pv), .stop_valve_closed(sv), .cv_oil_low(oil),
        .steam_isolation(iso), .pool_temp_high(pool), .neutron_trip(ntr), .div_power_ok(pwr_ok),
        .manual_button_a(btn_a), .manual_button_b(btn_b), .switch_div2_n(sw2), .switch_div3_n(sw3),
        .backup_relay_n(bk_n), .rod_follow_n(fol_n), .pump_trip_n(pump_n), .div_trip_n(dtrip_n));
    task automatic complete_run;
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : complete_run
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e)
        begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc
    // Handshakes judged at the taking edge itself; one idle edge between calls
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic done;
        done = 1'h0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        while (!done)
        begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'h0;
            if (wvalid && wready) wvalid <= 1'h0;
            if (bvalid === 1'h1)
            begin
                wr_b = bresp;
                bready <= 1'h0;
                done = 1'h1;
            end
        end
    endtask : wr
    task automatic rd(input logic [7:0] a);
        logic done;
        done = 1'h0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        while (!done)
        begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'h0;
            if (rvalid === 1'h1)
            begin
                rd_d = rdata;
                rd_r = rresp;
                rready <= 1'h0;
                done = 1'h1;
            end
        end
    endtask : rd
    // Waits out the seal-in delay, then asks for reset with causes gone
    task automatic clr;
        cyc(25);
        wr(ADDR_CTRL, 32'h1);
        cyc(4);
        chk("follow cleared", 32'h1, 32'(fol_n));
        chk("switches cleared", 32'hFF, 32'(sw2));
    endtask : clr
    initial
    begin
        #400000;
        n_errors++;
        complete_run;
    end
    initial
    begin
        cyc(4);
        resetn <= 1'h1;
        cyc(2);
        chk("switch at reset", 32'h0, 32'(sw3));
        clr;
        rd(ADDR_SP_BASE);
        chk("setpoint reset", 32'hC000, rd_d);
        rd(8'hFC);
        chk("unmapped resp", 32'(RESP_SLVERR), 32'(rd_r));
        wr(8'h60, 32'hABCD1234);
        rd(8'h60);
        chk("setpoint write", 32'h1234, rd_d);
        wr(8'hFC, 32'h0);
        chk("unmapped write", 32'(RESP_SLVERR), 32'(wr_b));
        press_hi <= 4'h1;
        cyc(5);
        chk("one division", 32'hFF, 32'(sw3));
        press_hi <= 4'h5;
        cyc(5);
        chk("backup relay", 32'h0, 32'(bk_n));
        chk("switches two", 32'h0, 32'(sw3));
        chk("div trips", 32'h0, 32'(dtrip_n));
        rd(ADDR_TRIPS);
        chk("trip vectors", 32'h00040004, rd_d);
        wr(ADDR_CTRL, 32'h1);
        cyc(4);
        chk("early reset", 32'h0, 32'(fol_n));
        cyc(25);
        wr(ADDR_CTRL, 32'h1);
        cyc(4);
        chk("reset live trip", 32'h0, 32'(fol_n));
        press_hi <= 4'h0;
        clr;
        sv <= 4'h3;
        cyc(5);
        chk("pump low power", 32'h1, 32'(pump_n));
        chk("valve low power", 32'h1, 32'(fol_n));
        pwr_hi <= 1'h1;
        cyc(5);
        chk("pump valve", 32'h0, 32'(pump_n));
        chk("valve scram", 32'h0, 32'(fol_n));
        sv <= 4'h0;
        oil <= 4'h9;
        cyc(5);
        chk("pump oil", 32'h0, 32'(pump_n));
        oil <= 4'h0;
        clr;
        chk("pump released", 32'h1, 32'(pump_n));
        oil <= 4'h9;
        cyc(5);
        chk("oil scram", 32'h0, 32'(sw2));
        oil <= 4'h0;
        clr;
        for (int k = 0; k < 3; k++)
        begin
            {iso, pool, ntr} <= 12'h600 >> (4 * k);
            cyc(5);
            chk("discrete scram", 32'h0, 32'(sw2));
            {iso, pool, ntr} <= 12'h000;
            clr;
        end
        btn_a <= 1'h1;
        cyc(3);
        chk("button a", 32'hF0FF, {16'h0, sw2, sw3});
        btn_a <= 1'h0;
        btn_b <= 1'h1;
        cyc(3);
        chk("button b", 32'hFF0F, {16'h0, sw2, sw3});
        chk("one button", 32'h1, 32'(fol_n));
        btn_a <= 1'h1;
        cyc(3);
        chk("both buttons", 32'h0, 32'({bk_n, fol_n, sw2}));
        rd(ADDR_STATUS);
        chk("status manual", 32'h5, rd_d);
        {btn_a, btn_b} <= 2'h0;
        clr;
        pwr_ok <= 4'hD;
        cyc(3);
        chk("dead division", 32'h00FF, 32'({sw2, sw3}));
        chk("dead vote", 32'hD, 32'(dtrip_n));
        complete_run;
    end
endmodule : protection_logic_tb
